// >>> src/cstat_pkg.sv
// package: constants for channel status and command acceptance
package cstat_pkg;
    localparam int NCHAN        = 16;
    localparam int CHW          = 4;
    localparam int NBLK         = 4;
    localparam int BPW          = 2;
    // line table byte offsets
    localparam logic [5:0] RX_LS1_OFS = 6'h10;
    localparam logic [5:0] RX_LS2_OFS = 6'h11;
    localparam logic [5:0] TX_LS1_OFS = 6'h30;
    localparam logic [5:0] TX_LS2_OFS = 6'h31;
    // control block status byte offsets
    localparam logic [2:0] BLK_ST2_OFS = 3'h6;
    localparam logic [2:0] BLK_ST1_OFS = 3'h7;
    // line status one fields
    localparam int LS1_PROG_INT  = 0;
    localparam int LS1_DSET_INT  = 1;
    localparam int LS1_DATA_SVC  = 2;
    localparam int LS1_BLK_SVC   = 4;
    localparam int LS1_USER_LO   = 5;
    localparam int LS1_USER_HI   = 6;
    // line status two fields
    localparam int LS2_DATA_CHK  = 1;
    localparam int LS2_DSET_CHG  = 3;
    localparam int LS2_MEM_CORR  = 4;
    // block status one fields
    localparam int BS1_PROG_INT  = 0;
    localparam int BS1_HOST_INT  = 1;
    localparam int BS1_VALID     = 3;
    // configuration byte bit enabling data set interrupt
    localparam int CFG_DSET_EN   = 2;
    localparam logic [7:0] LS_RESET  = 8'h00;
    localparam logic [7:0] USER_MASK = 8'h60;
    // initialization length, in cycles
    localparam int INIT_CYCLES = 64;
    // host command codes
    typedef enum logic [2:0] {
        CSTAT_CMD_INIT,
        CSTAT_CMD_BLK_LOAD,
        CSTAT_CMD_BLK_STAT,
        CSTAT_CMD_NEXT_STAT,
        CSTAT_CMD_LT_READ,
        CSTAT_CMD_LIST_INIT,
        CSTAT_CMD_OTHER
    } cstat_cmd_t;
endpackage

// >>> src/cstat_chan.sv
// one channel direction: line status accumulation and transfer
`timescale 1ns/1ps
`default_nettype none
module cstat_chan (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] set1,
    input  wire logic [7:0] set2,
    input  wire logic       user_we,
    input  wire logic [7:0] user_wd,
    input  wire logic       done,
    input  wire logic       host_int,
    output logic      [7:0] ls1_r,
    output logic      [7:0] ls2_r,
    output logic      [7:0] bs1_xfer,
    output logic      [7:0] bs2_xfer
);
    logic [7:0] ls1_nxt;
    logic [7:0] ls2_nxt;
    logic [7:0] user_keep;
    assign user_keep = user_we ? (user_wd & cstat_pkg::USER_MASK)
                               : (ls1_r & cstat_pkg::USER_MASK);
    // set only, except user bits 5 and 6 written on user_we; cleared right after transfer
    assign ls1_nxt = done ? cstat_pkg::LS_RESET
                   : (((ls1_r & ~cstat_pkg::USER_MASK) | user_keep) | set1);
    assign ls2_nxt = done ? cstat_pkg::LS_RESET : (ls2_r | set2);
    // merged status including any event of the final cycle
    logic [7:0] m1;
    assign m1 = ((ls1_r & ~cstat_pkg::USER_MASK) | user_keep) | set1;
    assign bs1_xfer = m1 | (8'h01 << cstat_pkg::BS1_VALID)
                    | ({7'h00, host_int} << cstat_pkg::BS1_HOST_INT);
    assign bs2_xfer = ls2_r | set2;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls1_r <= cstat_pkg::LS_RESET;
            ls2_r <= cstat_pkg::LS_RESET;
        end else begin
            ls1_r <= ls1_nxt;
            ls2_r <= ls2_nxt;
        end
    end
    a_status_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(done) && !$past(user_we)
        |-> ((ls2_r & $past(ls2_r)) == $past(ls2_r))
            && ((ls1_r & $past(ls1_r)) == $past(ls1_r)))
        else $error("line status bit cleared while block active");
    a_clear_after: assert property (@(posedge core_clk) disable iff (!rst_n)
        done |=> (ls1_r == 8'h00 && ls2_r == 8'h00))
        else $error("line status not cleared after transfer");
endmodule
`default_nettype wire

// >>> src/cstat_ptr.sv
// control block list pointers and acceptance of block commands
`timescale 1ns/1ps
`default_nettype none
module cstat_ptr (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       list_init,
    input  wire logic       load_cmd,
    input  wire logic       next_cmd,
    output logic            load_nak,
    output logic            next_nak,
    output logic      [1:0] stat_ptr_r
);
    logic [1:0] load_ptr_r;
    logic [2:0] fill_r;
    // full: NBLK blocks outstanding, load pointer back round the ring at status pointer
    assign load_nak = (fill_r == 3'(cstat_pkg::NBLK));
    // empty: nothing set up since init or status caught up
    assign next_nak = (fill_r == 3'h0);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_ptr_r <= 2'h0;
            stat_ptr_r <= 2'h0;
            fill_r     <= 3'h0;
        end else if (list_init) begin
            load_ptr_r <= 2'h0;
            stat_ptr_r <= 2'h0;
            fill_r     <= 3'h0;
        end else begin
            if (load_cmd && !load_nak)
                load_ptr_r <= load_ptr_r + 2'h1;
            if (next_cmd && !next_nak)
                stat_ptr_r <= stat_ptr_r + 2'h1;
            fill_r <= fill_r + 3'({2'h0, load_cmd && !load_nak})
                             - 3'({2'h0, next_cmd && !next_nak});
        end
    end
    a_fill_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        fill_r <= 3'(cstat_pkg::NBLK))
        else $error("block list overfilled");
endmodule
`default_nettype wire

// >>> src/cstat_top.sv
// host command acceptance and per-channel status handling
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - nak every command except init while initialization runs
// - repeated init restarts initialization, no nak
// - nak block load when list is full
// - nak next status before first block loaded
// - nak next status when status caught up
// - status kept at line bytes 16/17, 48/49
// - program interrupt sets line status one bit0
// - data set interrupt sets line status one bit1
// - active block status bits only ever set, except bits 5 and 6 on a channel program write
// - line status merged into block bytes 7/6
// - line status cleared right after transfer
// - host and channel program read line status
// - channel program writes bits 5 and 6
// - completion sets block status valid bit3
// - program interrupt sets block status bit0
// - block status returned on both status commands
// - status byte one stored above byte two
// - data set bit needs enable, no termination
// - host interrupt sets block status bit1
module cstat_top (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   cmd_valid,
    input  wire cstat_pkg::cstat_cmd_t  cmd_code,
    input  wire logic [4:0]             cmd_chan,
    input  wire logic [5:0]             cmd_ofs,
    input  wire logic [1:0]             cmd_blk,
    input  wire logic [31:0]            prog_int,
    input  wire logic [31:0]            dset_chg,
    input  wire logic [31:0]            dset_en,
    input  wire logic [31:0]            data_svc_err,
    input  wire logic [31:0]            blk_svc_err,
    input  wire logic [31:0]            data_chk_err,
    input  wire logic [31:0]            mem_corr_err,
    input  wire logic [31:0]            blk_done,
    input  wire logic [31:0]            blk_host_int,
    input  wire logic [31:0]            user_we,
    input  wire logic [7:0]             user_wd,
    input  wire logic [4:0]             prog_rd_chan,
    input  wire logic                   prog_rd_sel,
    output logic                        cmd_ack_r,
    output logic                        cmd_nak_r,
    output logic [15:0]                 cmd_rdata_r,
    output logic [7:0]                  prog_rdata_r,
    output logic                        init_busy_r
);
    // ------------------------------------------------------------
    // initialization sequencing
    // ------------------------------------------------------------
    typedef enum logic [0:0] {CSTAT_IDLE, CSTAT_INIT} cstat_state_t;
    cstat_state_t state_r;
    logic [6:0]   init_cnt_r;
    logic         is_init;
    logic         init_done;
    assign is_init   = cmd_valid && (cmd_code == cstat_pkg::CSTAT_CMD_INIT);
    assign init_done = (state_r == CSTAT_INIT) && (init_cnt_r == 7'h00);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= CSTAT_IDLE;
            init_cnt_r <= 7'h00;
        end else if (is_init) begin
            state_r    <= CSTAT_INIT;
            init_cnt_r <= 7'(cstat_pkg::INIT_CYCLES - 1);
        end else begin
            unique case (state_r)
                CSTAT_IDLE: state_r <= CSTAT_IDLE;
                CSTAT_INIT: begin
                    if (init_done)
                        state_r <= CSTAT_IDLE;
                    else
                        init_cnt_r <= init_cnt_r - 7'h01;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // per-channel status and block memory
    // ------------------------------------------------------------
    logic [7:0]  ls1   [32];
    logic [7:0]  ls2   [32];
    logic [7:0]  bs1x  [32];
    logic [7:0]  bs2x  [32];
    logic [7:0]  blk_mem [32][cstat_pkg::NBLK][2];
    logic [1:0]  sptr  [32];
    logic [31:0] load_nak;
    logic [31:0] next_nak;
    logic [31:0] busy_clr;
    logic        cmd_ok;
    assign busy_clr = {32{init_done}};
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_ch
            logic [7:0] s1;
            logic [7:0] s2;
            logic       ldc;
            logic       nxc;
            logic       lic;
            assign s1 = ({7'h00, prog_int[g]} << cstat_pkg::LS1_PROG_INT)
                      | ({7'h00, dset_chg[g] & dset_en[g]} << cstat_pkg::LS1_DSET_INT)
                      | ({7'h00, data_svc_err[g]} << cstat_pkg::LS1_DATA_SVC)
                      | ({7'h00, blk_svc_err[g]} << cstat_pkg::LS1_BLK_SVC);
            assign s2 = ({7'h00, data_chk_err[g]} << cstat_pkg::LS2_DATA_CHK)
                      | ({7'h00, dset_chg[g]} << cstat_pkg::LS2_DSET_CHG)
                      | ({7'h00, mem_corr_err[g]} << cstat_pkg::LS2_MEM_CORR);
            assign ldc = cmd_ok && (cmd_chan == 5'(g))
                         && (cmd_code == cstat_pkg::CSTAT_CMD_BLK_LOAD);
            assign nxc = cmd_ok && (cmd_chan == 5'(g))
                         && (cmd_code == cstat_pkg::CSTAT_CMD_NEXT_STAT);
            assign lic = (cmd_ok && (cmd_chan == 5'(g))
                         && (cmd_code == cstat_pkg::CSTAT_CMD_LIST_INIT)) || busy_clr[g];
            // each channel owns its own status instance
            cstat_chan u_chan (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .set1     (s1),
                .set2     (s2),
                .user_we  (user_we[g]),
                .user_wd  (user_wd),
                .done     (blk_done[g]),
                .host_int (blk_host_int[g]),
                .ls1_r    (ls1[g]),
                .ls2_r    (ls2[g]),
                .bs1_xfer (bs1x[g]),
                .bs2_xfer (bs2x[g])
            );
            cstat_ptr u_ptr (
                .core_clk   (core_clk),
                .rst_n      (rst_n),
                .list_init  (lic),
                .load_cmd   (ldc),
                .next_cmd   (nxc),
                .load_nak   (load_nak[g]),
                .next_nak   (next_nak[g]),
                .stat_ptr_r (sptr[g])
            );
            // byte one sits at the higher address
            always_ff @(posedge core_clk) begin
                if (blk_done[g]) begin
                    blk_mem[g][sptr[g]][1] <= bs1x[g];
                    blk_mem[g][sptr[g]][0] <= bs2x[g];
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // command acceptance
    // ------------------------------------------------------------
    logic nak_now;
    logic is_load;
    logic is_next;
    assign is_load = cmd_code == cstat_pkg::CSTAT_CMD_BLK_LOAD;
    assign is_next = cmd_code == cstat_pkg::CSTAT_CMD_NEXT_STAT;
    assign nak_now = cmd_valid && !is_init
                   && ((state_r == CSTAT_INIT)
                       || (is_load && load_nak[cmd_chan])
                       || (is_next && next_nak[cmd_chan]));
    assign cmd_ok  = cmd_valid && !nak_now && !is_init;
    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [7:0]  lt_byte;
    logic [1:0]  rd_blk;
    logic [15:0] blk_word;
    logic [15:0] rdata_nxt;
    logic [7:0]  prog_nxt;
    assign lt_byte = (cmd_ofs == cstat_pkg::RX_LS1_OFS) ? ls1[{cmd_chan[4:1], 1'b0}]
                   : (cmd_ofs == cstat_pkg::RX_LS2_OFS) ? ls2[{cmd_chan[4:1], 1'b0}]
                   : (cmd_ofs == cstat_pkg::TX_LS1_OFS) ? ls1[{cmd_chan[4:1], 1'b1}]
                   : (cmd_ofs == cstat_pkg::TX_LS2_OFS) ? ls2[{cmd_chan[4:1], 1'b1}]
                   : 8'h00;
    assign rd_blk   = is_next ? sptr[cmd_chan] : cmd_blk;
    assign blk_word = {blk_mem[cmd_chan][rd_blk][1], blk_mem[cmd_chan][rd_blk][0]};
    assign rdata_nxt = (cmd_code == cstat_pkg::CSTAT_CMD_LT_READ) ? {8'h00, lt_byte}
                     : ((cmd_code == cstat_pkg::CSTAT_CMD_BLK_STAT) || is_next) ? blk_word
                     : 16'h0000;
    assign prog_nxt = prog_rd_sel ? ls2[prog_rd_chan] : ls1[prog_rd_chan];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ack_r    <= 1'b0;
            cmd_nak_r    <= 1'b0;
            cmd_rdata_r  <= 16'h0000;
            prog_rdata_r <= 8'h00;
            init_busy_r  <= 1'b0;
        end else begin
            cmd_ack_r    <= cmd_valid && !nak_now;
            cmd_nak_r    <= nak_now;
            cmd_rdata_r  <= cmd_ok ? rdata_nxt : 16'h0000;
            prog_rdata_r <= prog_nxt;
            init_busy_r  <= is_init || ((state_r == CSTAT_INIT) && !init_done);
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_init_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_valid && cmd_code != cstat_pkg::CSTAT_CMD_INIT && state_r == CSTAT_INIT
        |=> cmd_nak_r && !cmd_ack_r)
        else $error("command accepted during initialization");
    a_reinit_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_init |=> cmd_ack_r && !cmd_nak_r && init_busy_r)
        else $error("initialize command refused");
    a_init_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_init ##1 (!is_init) [*8] |-> init_busy_r)
        else $error("initialization ended early");
endmodule
`default_nettype wire

// >>> test/cstat_host.sv
// host program model issuing i/o commands with bounded retry
`timescale 1ns/1ps
`default_nettype none
module cstat_host (
    input  wire logic                  core_clk,
    input  wire logic                  cmd_ack_r,
    input  wire logic                  cmd_nak_r,
    input  wire logic [15:0]           cmd_rdata_r,
    output var  logic                  cmd_valid,
    output var  cstat_pkg::cstat_cmd_t cmd_code,
    output var  logic [4:0]            cmd_chan,
    output var  logic [5:0]            cmd_ofs,
    output var  logic [1:0]            cmd_blk
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = cstat_pkg::CSTAT_CMD_OTHER;
        cmd_chan = 5'h1f;
        cmd_ofs = 6'h3f;
        cmd_blk = 2'h3;
    end
    // one command, sent at most tries times in all until acked
    task automatic issue(input cstat_pkg::cstat_cmd_t c, input logic [4:0] ch,
                         input logic [5:0] o, input logic [1:0] b, input int tries,
                         output logic [1:0] resp, output logic [15:0] rdata);
        resp = 2'h0;
        rdata = 16'h0000;
        for (int i = 0; i < tries && resp !== 2'h2; i++) begin
            @(posedge core_clk);
            #1;
            cmd_valid = 1'b1;
            cmd_code = c;
            cmd_chan = ch;
            cmd_ofs = o;
            cmd_blk = b;
            @(posedge core_clk);
            #1;
            resp = {cmd_ack_r, cmd_nak_r};
            rdata = cmd_rdata_r;
            cmd_valid = 1'b0;
            cmd_chan = ~ch;
            cmd_ofs = ~o;
            cmd_blk = ~b;
        end
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for channel status and command acceptance
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {int k; logic en; logic [7:0] s1; logic [7:0] s2;} cstat_row_t;
    logic                  core_clk, rst_n, cmd_valid, prog_rd_sel;
    logic                  cmd_ack_r, cmd_nak_r, init_busy_r;
    cstat_pkg::cstat_cmd_t cmd_code;
    logic [4:0]            cmd_chan, prog_rd_chan;
    logic [5:0]            cmd_ofs;
    logic [1:0]            cmd_blk, rsp;
    logic [31:0]           ev [0:8];
    logic [31:0]           dset_en;
    logic [7:0]            user_wd, prog_rdata_r;
    logic [15:0]           cmd_rdata_r, rd;
    int                    bad_count, n_compared, n;
    cstat_row_t            rows [7];
    cstat_host host_u (.core_clk(core_clk), .cmd_ack_r(cmd_ack_r), .cmd_nak_r(cmd_nak_r),
        .cmd_rdata_r(cmd_rdata_r), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_chan(cmd_chan), .cmd_ofs(cmd_ofs), .cmd_blk(cmd_blk));
    cstat_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_chan(cmd_chan), .cmd_ofs(cmd_ofs), .cmd_blk(cmd_blk),
        .prog_int(ev[0]), .dset_chg(ev[1]), .dset_en(dset_en), .data_svc_err(ev[2]),
        .blk_svc_err(ev[3]), .data_chk_err(ev[4]), .mem_corr_err(ev[5]),
        .blk_done(ev[6]), .blk_host_int(ev[7]), .user_we(ev[8]), .user_wd(user_wd),
        .prog_rd_chan(prog_rd_chan), .prog_rd_sel(prog_rd_sel), .cmd_ack_r(cmd_ack_r),
        .cmd_nak_r(cmd_nak_r), .cmd_rdata_r(cmd_rdata_r), .prog_rdata_r(prog_rdata_r),
        .init_busy_r(init_busy_r));
    // ------------------------------------------------------------
    // clock, tasks
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input cstat_pkg::cstat_cmd_t c, input int ch, input logic [5:0] o,
                       input logic ea);
        host_u.issue(c, ch[4:0], o, 2'h0, 1, rsp, rd);
        chk("response", {14'h0000, ea, ~ea}, {14'h0000, rsp});
    endtask
    task automatic pulse(input int k, input int ch);
        @(posedge core_clk);
        #1;
        ev[k][ch] = 1'b1;
        @(posedge core_clk);
        #1;
        ev[k][ch] = 1'b0;
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #10000;
        bad_count++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        for (int i = 0; i < 9; i++) ev[i] = 32'h00000000;
        dset_en = 32'h00000000;
        user_wd = 8'h00;
        prog_rd_chan = 5'h00;
        prog_rd_sel = 1'b0;
        rows = '{'{0, 1'b0, 8'h01, 8'h00}, '{1, 1'b0, 8'h01, 8'h08},
                 '{1, 1'b1, 8'h03, 8'h08}, '{2, 1'b0, 8'h07, 8'h08},
                 '{3, 1'b0, 8'h17, 8'h08}, '{4, 1'b0, 8'h17, 8'h0a},
                 '{5, 1'b0, 8'h17, 8'h1a}};
        repeat (4) @(posedge core_clk);
        #1;
        chk("reset outputs", 16'h0000, {5'h00, cmd_ack_r, cmd_nak_r, init_busy_r, prog_rdata_r});
        chk("reset data", 16'h0000, cmd_rdata_r);
        rst_n = 1'b1;
        cmd(cstat_pkg::CSTAT_CMD_INIT, 0, 6'h00, 1'b1);
        chk("init busy", 16'h0001, {15'h0000, init_busy_r});
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 0, 6'h10, 1'b0);
        cmd(cstat_pkg::CSTAT_CMD_INIT, 0, 6'h00, 1'b1);
        n = 0;
        while (init_busy_r !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("init restart span", 16'(cstat_pkg::INIT_CYCLES), 16'(n));
        cmd(cstat_pkg::CSTAT_CMD_NEXT_STAT, 0, 6'h00, 1'b0);
        cmd(cstat_pkg::CSTAT_CMD_LIST_INIT, 0, 6'h00, 1'b1);
        cmd(cstat_pkg::CSTAT_CMD_NEXT_STAT, 0, 6'h00, 1'b0);
        foreach (rows[i]) begin
            dset_en[2] = rows[i].en;
            pulse(rows[i].k, 2);
            cmd(cstat_pkg::CSTAT_CMD_LT_READ, 2, 6'h10, 1'b1);
            chk("status one", {8'h00, rows[i].s1}, rd);
            cmd(cstat_pkg::CSTAT_CMD_LT_READ, 2, 6'h11, 1'b1);
            chk("status two", {8'h00, rows[i].s2}, rd);
        end
        dset_en[0] = 1'b1;
        user_wd = 8'hff;
        pulse(0, 0);
        pulse(1, 0);
        pulse(8, 0);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 0, 6'h10, 1'b1);
        chk("status one ch0", 16'h0063, rd);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 0, 6'h05, 1'b1);
        chk("unmapped byte", 16'h0000, rd);
        repeat (2) @(posedge core_clk);
        #1;
        chk("program read", 16'h0063, {8'h00, prog_rdata_r});
        prog_rd_sel = 1'b1;
        @(posedge core_clk);
        #1;
        chk("program read two", 16'h0008, {8'h00, prog_rdata_r});
        pulse(4, 0);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 1, 6'h30, 1'b1);
        chk("tx status one", 16'h0000, rd);
        pulse(5, 1);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 1, 6'h31, 1'b1);
        chk("tx status two", 16'h0010, rd);
        for (int i = 0; i < 4; i++) cmd(cstat_pkg::CSTAT_CMD_BLK_LOAD, 0, 6'h00, 1'b1);
        cmd(cstat_pkg::CSTAT_CMD_BLK_LOAD, 0, 6'h00, 1'b0);
        ev[7][0] = 1'b1;
        pulse(6, 0);
        ev[7][0] = 1'b0;
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 0, 6'h10, 1'b1);
        chk("cleared one", 16'h0000, rd);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 0, 6'h11, 1'b1);
        chk("cleared two", 16'h0000, rd);
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 2, 6'h10, 1'b1);
        chk("other channel", 16'h0017, rd);
        cmd(cstat_pkg::CSTAT_CMD_NEXT_STAT, 0, 6'h00, 1'b1);
        chk("next status", 16'h6b0a, rd);
        cmd(cstat_pkg::CSTAT_CMD_BLK_STAT, 0, 6'h00, 1'b1);
        chk("block status", 16'h6b0a, rd);
        cmd(cstat_pkg::CSTAT_CMD_BLK_LOAD, 0, 6'h00, 1'b1);
        for (int i = 0; i < 4; i++) cmd(cstat_pkg::CSTAT_CMD_NEXT_STAT, 0, 6'h00, 1'b1);
        cmd(cstat_pkg::CSTAT_CMD_NEXT_STAT, 0, 6'h00, 1'b0);
        pulse(6, 0);
        host_u.issue(cstat_pkg::CSTAT_CMD_BLK_STAT, 5'h00, 6'h00, 2'h1, 1, rsp, rd);
        chk("plain block status", 16'h0800, rd);
        // ------------------------------------------------------------
        // mid-run reset, bounded retry
        // ------------------------------------------------------------
        rst_n = 1'b0;
        @(posedge core_clk);
        #1;
        chk("mid reset outputs", 16'h0000,
            {5'h00, cmd_ack_r, cmd_nak_r, init_busy_r, prog_rdata_r});
        chk("mid reset data", 16'h0000, cmd_rdata_r);
        rst_n = 1'b1;
        cmd(cstat_pkg::CSTAT_CMD_LT_READ, 2, 6'h10, 1'b1);
        chk("status after reset", 16'h0000, rd);
        cmd(cstat_pkg::CSTAT_CMD_INIT, 0, 6'h00, 1'b1);
        host_u.issue(cstat_pkg::CSTAT_CMD_LT_READ, 5'h02, 6'h10, 2'h0, 3, rsp, rd);
        chk("bounded retry", 16'h0001, {14'h0000, rsp});
        report_and_stop();
    end
endmodule
`default_nettype wire
